// ### common/sdis_pkg.sv
// constants shared by the sd host event and error status block
package sdis_pkg;
    // register byte offsets on the wishbone port
    localparam logic [7:0] SDIS_OFF_STATUS  = 8'h30;
    localparam logic [7:0] SDIS_OFF_STAT_EN = 8'h34;
    localparam logic [7:0] SDIS_OFF_SIG_EN  = 8'h38;
    localparam logic [7:0] SDIS_OFF_CTRL    = 8'h40;
    // status bit positions
    localparam int SDIS_B_CMD_DONE   = 0;
    localparam int SDIS_B_XFER_DONE  = 1;
    localparam int SDIS_B_BLK_GAP    = 2;
    localparam int SDIS_B_DMA        = 3;
    localparam int SDIS_B_WR_READY   = 4;
    localparam int SDIS_B_RD_READY   = 5;
    localparam int SDIS_B_CARD_IN    = 6;
    localparam int SDIS_B_CARD_OUT   = 7;
    localparam int SDIS_B_CARD_INT   = 8;
    localparam int SDIS_B_ERR_SUM    = 15;
    localparam int SDIS_B_CMD_TMO    = 16;
    localparam int SDIS_B_CMD_CRC    = 17;
    localparam int SDIS_B_CMD_ENDBIT = 18;
    localparam int SDIS_B_CMD_INDEX  = 19;
    localparam int SDIS_B_DAT_TMO    = 20;
    localparam int SDIS_B_DAT_CRC    = 21;
    localparam int SDIS_B_DAT_ENDBIT = 22;
    localparam int SDIS_B_CTRL_WIDE  = 0;
    // implemented bits of each register
    localparam logic [31:0] SDIS_STAT_MASK = 32'h007f_81ff;
    localparam logic [31:0] SDIS_EN_MASK   = 32'h007f_01ff;
    localparam logic [31:0] SDIS_ERR_MASK  = 32'h007f_0000;
    localparam logic [31:0] SDIS_RST_VAL   = 32'h0000_0000;
    // response must start within this many sdclk cycles
    localparam logic [6:0]  SDIS_RESP_WINDOW = 7'h40;
    // good write crc status token
    localparam logic [2:0]  SDIS_WCRC_GOOD = 3'h2;
endpackage : sdis_pkg

// ### hdl/sdis_status.sv
// sd host event and error status register with wishbone slave
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - zero data end bit flags data end error
// - read crc or bad token flags crc
// - four data timeouts set data timeout
// - response index mismatch sets index error
// - zero response end bit sets end error
// - response crc fail sets crc if no timeout
// - cmd conflict aborts drive, sets crc, timeout
// - no response in 64 sdclk sets timeout
// - conflict sets timeout at once
// - bit 15 reads one on any error
// - card interrupt ignores writes, follows card
// - 1-bit always samples, 4-bit in period
// - clearing enable drops latched card interrupt
// - card detect edges set insert, remove flags
// - buffer enable rising edges set ready flags
// - dma boundary sets dma interrupt flag
// - stop request plus edge sets block gap
// - read active fall sets transfer complete
// - write dat active fall sets transfer complete
// - response end sets command complete, not auto
// - write one clears, zero keeps, many at once
// - interrupt when set bit has signal enable
module sdis_status
    import sdis_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    output logic             irq_o,
    // pins from the card side
    input  wire logic        sdclk_i,
    input  wire logic        cmd_line_i,
    input  wire logic        card_detect_i,
    input  wire logic        dat1_int_n_i,
    // command engine, same clock
    input  wire logic        cmd_start_i,
    input  wire logic        cmd_oe_i,
    input  wire logic        cmd_out_i,
    output logic             cmd_oe_o,
    input  wire logic        cmd_end_i,
    input  wire logic        resp_start_i,
    input  wire logic        resp_end_i,
    input  wire logic        resp_auto12_i,
    input  wire logic        resp_index_ok_i,
    input  wire logic        resp_end_bit_i,
    input  wire logic        resp_crc_ok_i,
    // data engine, same clock
    input  wire logic        rd_end_strobe_i,
    input  wire logic        rd_end_bit_i,
    input  wire logic        rd_crc_fail_i,
    input  wire logic        wcrc_strobe_i,
    input  wire logic [2:0]  wcrc_token_i,
    input  wire logic        wcrc_end_bit_i,
    input  wire logic [3:0]  dat_tmo_i,
    input  wire logic        buf_rd_en_i,
    input  wire logic        buf_wr_en_i,
    input  wire logic        dma_boundary_i,
    input  wire logic        stop_gap_i,
    input  wire logic        xfer_write_i,
    input  wire logic        dat_active_i,
    input  wire logic        rd_active_i,
    input  wire logic        wr_active_i,
    input  wire logic        int_period_i,
    output logic             card_inserted_o
);
    logic [31:0] flags_r;
    logic [31:0] stat_en_r;
    logic [31:0] sig_en_r;
    logic        wide_r;
    logic        ack_r;
    logic [31:0] rdata_r;
    logic [31:0] status_view;
    logic [31:0] wmask;
    logic [31:0] clr;
    logic [31:0] set;
    logic        wr_stb;
    // synchronisers for pins
    logic        sclk_s1, sclk_s2, sclk_d;
    logic        cmd_s1, cmd_s2;
    logic        det_s1, det_s2, det_d;
    logic        int_s1, int_s2;
    logic        sclk_rise;
    // command line monitor
    logic        drove_one_r;
    logic        abort_r;
    logic        conflict;
    logic        waiting_r;
    logic [6:0]  resp_cnt_r;
    logic        resp_tmo;
    // edge detectors on local levels
    logic        rd_en_d, wr_en_d, dat_act_d, rd_act_d, wr_act_d;
    logic        cint_r;
    logic        cint_nxt;

    // two flip-flop synchronisers, only the second stage is read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_d  <= 1'b0;
            cmd_s1  <= 1'b1;
            cmd_s2  <= 1'b1;
            det_s1  <= 1'b0;
            det_s2  <= 1'b0;
            det_d   <= 1'b0;
            int_s1  <= 1'b1;
            int_s2  <= 1'b1;
        end else begin
            sclk_s1 <= sdclk_i;
            sclk_s2 <= sclk_s1;
            sclk_d  <= sclk_s2;
            cmd_s1  <= cmd_line_i;
            cmd_s2  <= cmd_s1;
            det_s1  <= card_detect_i;
            det_s2  <= det_s1;
            det_d   <= det_s2;
            int_s1  <= dat1_int_n_i;
            int_s2  <= int_s1;
        end
    end

    assign sclk_rise       = sclk_s2 & ~sclk_d;
    assign card_inserted_o = det_s2;

    // remember a driven one, check the line at the next sdclk edge
    assign conflict = sclk_rise & drove_one_r & ~cmd_s2;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drove_one_r <= 1'b0;
        end else if (sclk_rise) begin
            drove_one_r <= cmd_oe_o & cmd_out_i;
        end
    end

    // abort holds the driver off until the next command starts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            abort_r <= 1'b0;
        end else if (cmd_start_i) begin
            abort_r <= 1'b0;
        end else if (conflict) begin
            abort_r <= 1'b1;
        end
    end
    assign cmd_oe_o = cmd_oe_i & ~abort_r & ~conflict;

    // count sdclk edges from command end bit until a response begins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            waiting_r  <= 1'b0;
            resp_cnt_r <= 7'h00;
        end else if (cmd_end_i) begin
            waiting_r  <= 1'b1;
            resp_cnt_r <= 7'h00;
        end else if (resp_start_i || conflict || resp_tmo) begin
            waiting_r  <= 1'b0;
        end else if (waiting_r && sclk_rise) begin
            resp_cnt_r <= resp_cnt_r + 7'h01;
        end
    end
    assign resp_tmo = waiting_r & sclk_rise & ~resp_start_i
                    & (resp_cnt_r == SDIS_RESP_WINDOW - 7'h01);

    // delayed copies of local levels for edge detection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_en_d   <= 1'b0;
            wr_en_d   <= 1'b0;
            dat_act_d <= 1'b0;
            rd_act_d  <= 1'b0;
            wr_act_d  <= 1'b0;
        end else begin
            rd_en_d   <= buf_rd_en_i;
            wr_en_d   <= buf_wr_en_i;
            dat_act_d <= dat_active_i;
            rd_act_d  <= rd_active_i;
            wr_act_d  <= wr_active_i;
        end
    end

    // card interrupt follows the card while enabled
    always_comb begin
        cint_nxt = cint_r;
        if (!stat_en_r[SDIS_B_CARD_INT]) begin
            cint_nxt = 1'b0;
        end else if (!wide_r || int_period_i) begin
            cint_nxt = ~int_s2;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cint_r <= 1'b0;
        end else begin
            cint_r <= cint_nxt;
        end
    end

    // events that set sticky flags this cycle
    always_comb begin
        set = 32'h0000_0000;
        set[SDIS_B_DAT_ENDBIT] = (rd_end_strobe_i & ~rd_end_bit_i)
                               | (wcrc_strobe_i & ~wcrc_end_bit_i);
        set[SDIS_B_DAT_CRC]    = rd_crc_fail_i
                               | (wcrc_strobe_i
                                  & (wcrc_token_i != SDIS_WCRC_GOOD));
        set[SDIS_B_DAT_TMO]    = |dat_tmo_i;
        set[SDIS_B_CMD_INDEX]  = resp_end_i & ~resp_index_ok_i;
        set[SDIS_B_CMD_ENDBIT] = resp_end_i & ~resp_end_bit_i;
        set[SDIS_B_CMD_CRC]    = (resp_end_i & ~resp_crc_ok_i
                                  & ~flags_r[SDIS_B_CMD_TMO])
                               | conflict;
        set[SDIS_B_CMD_TMO]    = resp_tmo | conflict;
        set[SDIS_B_CARD_OUT]   = det_d & ~det_s2;
        set[SDIS_B_CARD_IN]    = ~det_d & det_s2;
        set[SDIS_B_RD_READY]   = buf_rd_en_i & ~rd_en_d;
        set[SDIS_B_WR_READY]   = buf_wr_en_i & ~wr_en_d;
        set[SDIS_B_DMA]        = dma_boundary_i;
        set[SDIS_B_BLK_GAP]    = stop_gap_i
                               & ((~xfer_write_i & dat_act_d & ~dat_active_i)
                               | (xfer_write_i & wr_act_d & ~wr_active_i));
        set[SDIS_B_XFER_DONE]  = (~xfer_write_i & rd_act_d & ~rd_active_i)
                               | (xfer_write_i & dat_act_d & ~dat_active_i);
        set[SDIS_B_CMD_DONE]   = resp_end_i & ~resp_auto12_i;
    end

    // byte lane mask and write strobe of a wishbone write
    assign wr_stb = cyc_i & stb_i & we_i & ~ack_r;
    assign wmask  = {{8{sel_i[3]}}, {8{sel_i[2]}},
                     {8{sel_i[1]}}, {8{sel_i[0]}}};
    assign clr    = (wr_stb && adr_i == SDIS_OFF_STATUS)
                  ? (dat_i & wmask & SDIS_STAT_MASK) : 32'h0000_0000;

    // sticky flags, a set in the clearing cycle wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_r <= SDIS_RST_VAL;
        end else begin
            flags_r <= ((flags_r & ~clr) | set) & SDIS_EN_MASK
                     & ~(32'h1 << SDIS_B_CARD_INT);
        end
    end

    // status view with summary and card interrupt
    always_comb begin
        status_view = flags_r;
        status_view[SDIS_B_CARD_INT] = cint_r;
        status_view[SDIS_B_ERR_SUM]  = |(flags_r & SDIS_ERR_MASK);
    end

    // enable registers and width control
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_en_r <= SDIS_RST_VAL;
            sig_en_r  <= SDIS_RST_VAL;
            wide_r    <= 1'b0;
        end else if (wr_stb) begin
            if (adr_i == SDIS_OFF_STAT_EN) begin
                stat_en_r <= ((stat_en_r & ~wmask) | (dat_i & wmask))
                           & SDIS_EN_MASK;
            end
            if (adr_i == SDIS_OFF_SIG_EN) begin
                sig_en_r <= ((sig_en_r & ~wmask) | (dat_i & wmask))
                          & SDIS_EN_MASK;
            end
            if (adr_i == SDIS_OFF_CTRL && sel_i[0]) begin
                wide_r <= dat_i[SDIS_B_CTRL_WIDE];
            end
        end
    end

    // one wait state: ack and read data one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= cyc_i & stb_i & ~ack_r;
            unique case (adr_i)
                SDIS_OFF_STATUS:  rdata_r <= status_view;
                SDIS_OFF_STAT_EN: rdata_r <= stat_en_r;
                SDIS_OFF_SIG_EN:  rdata_r <= sig_en_r;
                SDIS_OFF_CTRL:    rdata_r <= {31'h0, wide_r};
                default:          rdata_r <= 32'h0000_0000;
            endcase
        end
    end
    assign ack_o = ack_r;
    assign dat_o = rdata_r;

    // single host interrupt line
    assign irq_o = |(status_view & sig_en_r & SDIS_EN_MASK);

    // checks next to the logic they guard
    sequence s_drove_one;
        sclk_rise && cmd_oe_o && cmd_out_i;
    endsequence
    // line found low at an sdclk rise after a driven one, no restart
    sequence s_line_low_next;
        sclk_rise && drove_one_r && !cmd_s2 && !cmd_start_i;
    endsequence

    a_summary_bit: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && dat_o[SDIS_B_ERR_SUM] |-> $past(|(flags_r & SDIS_ERR_MASK)))
        else $error("summary bit without error flag");
    a_cmd_done: assert property (@(posedge clk_i) disable iff (rst_i)
        resp_end_i && !resp_auto12_i |=> flags_r[SDIS_B_CMD_DONE])
        else $error("command complete not set");
    a_cmd_index: assert property (@(posedge clk_i) disable iff (rst_i)
        resp_end_i && !resp_index_ok_i |=> flags_r[SDIS_B_CMD_INDEX])
        else $error("index error not set");
    a_resp_endbit: assert property (@(posedge clk_i) disable iff (rst_i)
        resp_end_i && !resp_end_bit_i |=> flags_r[SDIS_B_CMD_ENDBIT])
        else $error("end bit error not set");
    a_crc_gated: assert property (@(posedge clk_i) disable iff (rst_i)
        resp_end_i && !resp_crc_ok_i && !flags_r[SDIS_B_CMD_TMO]
        |=> flags_r[SDIS_B_CMD_CRC])
        else $error("response crc error not set");
    a_line_conflict: assert property (@(posedge clk_i) disable iff (rst_i)
        s_drove_one ##[1:40] s_line_low_next |=> flags_r[SDIS_B_CMD_CRC]
        && flags_r[SDIS_B_CMD_TMO] && !cmd_oe_o)
        else $error("conflict not flagged");
    a_resp_window: assert property (@(posedge clk_i) disable iff (rst_i)
        resp_tmo |-> waiting_r && resp_cnt_r == 7'h3f)
        else $error("timeout at wrong count");
    a_card_insert: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(det_s2) |=> flags_r[SDIS_B_CARD_IN])
        else $error("card insertion not set");
    a_buf_ready: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(buf_rd_en_i) |=> flags_r[SDIS_B_RD_READY])
        else $error("buffer read ready not set");
    a_cint_drop: assert property (@(posedge clk_i) disable iff (rst_i)
        !stat_en_r[SDIS_B_CARD_INT] |=> !cint_r)
        else $error("card interrupt kept while disabled");
    a_xfer_read: assert property (@(posedge clk_i) disable iff (rst_i)
        !xfer_write_i && $fell(rd_active_i) |=> flags_r[SDIS_B_XFER_DONE])
        else $error("read transfer complete not set");
    a_w1c_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        clr[SDIS_B_DMA] && !dma_boundary_i |=> !flags_r[SDIS_B_DMA])
        else $error("write one did not clear");
endmodule : sdis_status
`default_nettype wire

// ### verif/sdis_card_model.sv
// card side model: card clock, pulled-up cmd line, detect and interrupt pins
`timescale 1ns/100ps
`default_nettype none
module sdis_card_model (
    input  wire logic clk_run_i,
    input  wire logic present_i,
    input  wire logic irq_req_i,
    input  wire logic clash_i,
    input  wire logic host_oe_i,
    input  wire logic host_out_i,
    output logic      sdclk_o,
    output logic      cmd_line_o,
    output logic      card_detect_o,
    output logic      dat1_int_n_o
);
    // 160 ns card clock that stands low while the bench stops it
    initial sdclk_o = 1'b0;
    always begin
        #80;
        sdclk_o = clk_run_i ? ~sdclk_o : 1'b0;
    end
    // cmd has a pull-up; a clashing card pulls it low over the host
    assign cmd_line_o = clash_i ? 1'b0 : (host_oe_i ? host_out_i : 1'b1);
    // detect is high with a card in; the interrupt line idles high
    assign card_detect_o = present_i;
    assign dat1_int_n_o = ~irq_req_i;
endmodule : sdis_card_model
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench for the sd host event and error status block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import sdis_pkg::*;
    localparam logic [7:0] ST = SDIS_OFF_STATUS;
    logic        clk_i = 1'b0, rst_i = 1'b1;
    logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0, dat_o, rdat;
    logic        ack_o, irq_o, cmd_oe_o, card_inserted_o;
    logic        sdclk_i, cmd_line_i, card_detect_i, dat1_int_n_i;
    logic        cmd_start_i = 1'b0, cmd_oe_i = 1'b0, cmd_out_i = 1'b0;
    logic        int_period_i = 1'b0;
    logic        run = 1'b0, present = 1'b0, irq_req = 1'b0, clash = 1'b0;
    logic [26:0] ev = '0;
    int          error_cnt = 0, n_tests = 0, i;
    // per case: first and second engine pattern, expected status
    localparam logic [26:0] TA [22] = '{
        27'h200001d, 27'h0800000, 27'h0600000, 27'h0500000, 27'h1300000,
        27'h0080000, 27'h0040000, 27'h0020000, 27'h000000d, 27'h0000015,
        27'h0000019, 27'h000001f, 27'h0002000, 27'h0004000, 27'h0008000,
        27'h0010000, 27'h0000080, 27'h0001b00, 27'h0000500, 27'h0000020,
        27'h0001500, 27'h0000060};
    localparam logic [26:0] TB [22] = '{2: 27'h0200000, 3: 27'h0100000,
        4: 27'h0300000, default: 27'h0};
    localparam logic [31:0] TE [22] = '{
        32'h1, 32'h2, 32'h2, 32'h4, 32'h4, 32'h8, 32'h10, 32'h20,
        32'h28001, 32'h48001, 32'h88001, 32'h0, 32'h108000, 32'h108000,
        32'h108000, 32'h108000, 32'h208000, 32'h208000, 32'h408000,
        32'h408000, 32'h0, 32'h0};

    always #10 clk_i = ~clk_i;

    // design under test, engine inputs packed into one pattern vector
    sdis_status i_dut (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .irq_o, .sdclk_i, .cmd_line_i, .card_detect_i,
        .dat1_int_n_i, .cmd_start_i, .cmd_oe_i, .cmd_out_i, .cmd_oe_o,
        .cmd_end_i(ev[26]), .resp_start_i(ev[25]), .resp_end_i(ev[0]),
        .resp_auto12_i(ev[1]), .resp_index_ok_i(ev[2]),
        .resp_end_bit_i(ev[3]), .resp_crc_ok_i(ev[4]),
        .rd_end_strobe_i(ev[5]), .rd_end_bit_i(ev[6]),
        .rd_crc_fail_i(ev[7]), .wcrc_strobe_i(ev[8]),
        .wcrc_token_i(ev[11:9]), .wcrc_end_bit_i(ev[12]),
        .dat_tmo_i(ev[16:13]), .buf_rd_en_i(ev[17]), .buf_wr_en_i(ev[18]),
        .dma_boundary_i(ev[19]), .stop_gap_i(ev[20]),
        .xfer_write_i(ev[21]), .dat_active_i(ev[22]), .rd_active_i(ev[23]),
        .wr_active_i(ev[24]), .int_period_i, .card_inserted_o
    );

    // far side: card clock, cmd wire, detect and interrupt pins
    sdis_card_model i_card (
        .clk_run_i(run), .present_i(present), .irq_req_i(irq_req),
        .clash_i(clash), .host_oe_i(cmd_oe_o), .host_out_i(cmd_out_i),
        .sdclk_o(sdclk_i), .cmd_line_o(cmd_line_i),
        .card_detect_o(card_detect_i), .dat1_int_n_o(dat1_int_n_i)
    );

    // verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    // compare seen against expected and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
        end
    endtask : chk

    task automatic chb(input logic seen, input logic want);
        chk({31'h0, seen}, {31'h0, want});
    endtask : chb

    // one classic wishbone cycle, waiting a bounded time for ack
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        for (n = 0; n < 20 && ack_o !== 1'b1; n++)
            @(posedge clk_i);
        if (ack_o !== 1'b1) begin
            error_cnt++;
            report_and_stop();
        end
        rdat = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] want);
        wb(1'b0, a, 32'h0);
        chk(rdat, want);
    endtask : rdc

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask : idle

    // main sequence
    initial begin
        idle(4);
        rst_i <= 1'b0;
        rdc(ST, SDIS_RST_VAL);
        rdc(SDIS_OFF_STAT_EN, 32'h0);
        rdc(SDIS_OFF_SIG_EN, 32'h0);
        wr(8'h3c, 32'hffff_ffff);
        rdc(8'h3c, 32'h0);
        wr(SDIS_OFF_SIG_EN, 32'hffff_ffff);
        rdc(SDIS_OFF_SIG_EN, SDIS_EN_MASK);
        rdc(ST, SDIS_RST_VAL);
        // every engine event: flag, summary, interrupt line, clear
        for (i = 0; i < 22; i++) begin
            @(posedge clk_i) ev <= TA[i];
            @(posedge clk_i) ev <= TB[i];
            @(posedge clk_i) ev <= '0;
            rdc(ST, TE[i]);
            chb(irq_o, TE[i] != 32'h0);
            wr(ST, TE[i]);
            rdc(ST, 32'h0);
        end
        // read ends together with a read data timeout: both flags stand
        @(posedge clk_i) ev <= 27'h0800000;
        @(posedge clk_i) ev <= 27'h0002000;
        @(posedge clk_i) ev <= '0;
        rdc(ST, 32'h0010_8002);
        wr(ST, 32'h0010_0002);
        rdc(ST, 32'h0);
        // no response: quiet near 60 card clocks, flagged by 72
        run <= 1'b1;
        @(posedge clk_i) ev <= 27'h4000000;
        @(posedge clk_i) ev <= '0;
        idle(480);
        rdc(ST, 32'h0);
        idle(96);
        rdc(ST, 32'h0001_8000);
        // late response with bad crc while timeout stands: no crc error
        @(posedge clk_i) ev <= 27'h000000d;
        @(posedge clk_i) ev <= '0;
        rdc(ST, 32'h0001_8001);
        wr(ST, 32'h0001_0001);
        // card holds cmd low while the host drives a one
        cmd_oe_i <= 1'b1;
        cmd_out_i <= 1'b1;
        clash <= 1'b1;
        idle(40);
        chb(cmd_oe_o, 1'b0);
        rdc(ST, 32'h0003_8000);
        clash <= 1'b0;
        run <= 1'b0;
        @(posedge clk_i) cmd_start_i <= 1'b1;
        @(posedge clk_i) cmd_start_i <= 1'b0;
        @(posedge clk_i) cmd_oe_i <= 1'b1;
        chb(cmd_oe_o, 1'b1);
        cmd_oe_i <= 1'b0;
        wr(ST, 32'h0003_0000);
        // card inserted, then removed; clearing one keeps the other
        present <= 1'b1;
        idle(8);
        chb(card_inserted_o, 1'b1);
        rdc(ST, 32'h40);
        present <= 1'b0;
        idle(8);
        rdc(ST, 32'hc0);
        wr(ST, 32'h40);
        rdc(ST, 32'h80);
        chb(card_inserted_o, 1'b0);
        wr(ST, 32'h80);
        // card interrupt, 1-bit mode with the card clock stopped
        wr(SDIS_OFF_SIG_EN, 32'h100);
        wr(SDIS_OFF_STAT_EN, 32'h100);
        irq_req <= 1'b1;
        idle(8);
        rdc(ST, 32'h100);
        chb(irq_o, 1'b1);
        wr(ST, 32'h100);
        rdc(ST, 32'h100);
        wr(SDIS_OFF_STAT_EN, 32'h0);
        rdc(ST, 32'h0);
        chb(irq_o, 1'b0);
        // 4-bit mode samples only inside the interrupt period
        wr(SDIS_OFF_CTRL, 32'h1);
        wr(SDIS_OFF_STAT_EN, 32'h100);
        idle(8);
        rdc(ST, 32'h0);
        int_period_i <= 1'b1;
        idle(8);
        rdc(ST, 32'h100);
        irq_req <= 1'b0;
        idle(8);
        rdc(ST, 32'h0);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
